// [core/ocd_output6.sv]
// Output-six source select, divider and driver configuration
// Function
// (R01) Source code 0 picks synthesizer one, 1 synthesizer two, 2 the primary reference, 3 the secondary reference.
// (R02) Format code 0 disables the output, 1 picks AC differential, 2 HCSL, 3 LVCMOS.
// (R03) Drive mode A sets tail current 4/6/8/16-or-8 mA, or in CMOS the positive leg state and polarity.
// (R04) Drive mode B sets the HCSL load tristate/50/100/200 ohm, or in CMOS the negative leg state and polarity.
// (R05) The divider value N divides the source by N plus one, from 1 to 256.
// (R06) The divider acts only on a synthesizer source; a reference passes undivided.
// (R07) Source and ratio changes take effect only at output period boundaries, never mid-pulse; with format code 0 the code applies them at once.
`timescale 1ns/1ps
module ocd_output6
   import ocd_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              reset_n,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [DATA_W-1:0] regWrData,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   output logic      [DATA_W-1:0] regRdData_q,
   input  wire logic              synthOneClk,
   input  wire logic              synthTwoClk,
   input  wire logic              refPrimaryClk,
   input  wire logic              refSecondaryClk,
   output ocd_ctrl_t              driverCfg_q,
   output logic                   clkPos_q,
   output logic                   clkNeg_q,
   output logic                   posOe_q,
   output logic                   negOe_q
);

   ocd_ctrl_t   ctrl_q;
   ocd_ctrl_t   ctrl_d;
   logic [7:0]  div_q;
   logic [7:0]  div_d;
   ocd_src_t    activeSrc_q;
   ocd_src_t    activeSrc_d;
   logic [7:0]  activeDiv_q;
   logic [7:0]  activeDiv_d;
   logic [7:0]  rdData_d;
   logic        clkPos_d;
   logic        clkNeg_d;
   logic        posOe_d;
   logic        negOe_d;
   logic        srcLevel;
   logic        bypass;
   logic        divClk;
   logic        boundary;
   logic        pending;

   // Register file
   always_comb begin
      ctrl_d = ctrl_q;
      div_d  = div_q;
      if (regWrite && regAddr == OUT6_CTRL_ADDR) begin
         ctrl_d = ocd_ctrl_t'(regWrData);
      end
      if (regWrite && regAddr == OUT6_DIV_ADDR) begin
         div_d = regWrData;
      end
   end

   assign pending = (activeSrc_q != ctrl_q.source) || (activeDiv_q != div_q);

   always_comb begin
      rdData_d = 8'h00;
      if (regRead) begin
         unique case (regAddr)
            OUT6_CTRL_ADDR:   rdData_d = ctrl_q;
            OUT6_DIV_ADDR:    rdData_d = div_q;
            OUT6_STATUS_ADDR: begin
               rdData_d[STAT_SRC_LSB +: 2]  = activeSrc_q;
               rdData_d[STAT_PENDING_BIT]   = pending;
            end
            default:          rdData_d = 8'h00;
         endcase
      end
   end

   // Source mux and shadowed settings
   always_comb begin
      unique case (activeSrc_q)
         SRC_SYNTH_ONE:     srcLevel = synthOneClk; // R01
         SRC_SYNTH_TWO:     srcLevel = synthTwoClk; // R01
         SRC_REF_PRIMARY:   srcLevel = refPrimaryClk; // R01
         SRC_REF_SECONDARY: srcLevel = refSecondaryClk; // R01
      endcase
   end

   assign bypass = (activeSrc_q == SRC_REF_PRIMARY) ||
                   (activeSrc_q == SRC_REF_SECONDARY); // R06

   // A stopped source would never reach a boundary, so a disabled
   // channel takes new settings at once; nothing is on the pins then.
   always_comb begin
      activeSrc_d = activeSrc_q;
      activeDiv_d = activeDiv_q;
      if (boundary || ctrl_q.format == FMT_DISABLED) begin
         activeSrc_d = ctrl_q.source; // R07
         activeDiv_d = div_q; // R07
      end
   end

   ocd_divider u_divider (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .srcLevel (srcLevel),
      .bypass   (bypass),
      .divRatio (activeDiv_q),
      .divClk_q (divClk),
      .boundary (boundary)
   );

   // Pad drive per format and leg modes
   always_comb begin
      clkPos_d = 1'b0;
      clkNeg_d = 1'b0;
      posOe_d  = 1'b0;
      negOe_d  = 1'b0;
      unique case (ctrl_q.format)
         FMT_DISABLED: begin
            posOe_d = 1'b0; // R02
            negOe_d = 1'b0; // R02
         end
         FMT_AC_DIFF: begin
            // Tail current code is passed on in driverCfg_q
            clkPos_d = divClk; // R03
            clkNeg_d = ~divClk;
            posOe_d  = 1'b1; // R02
            negOe_d  = 1'b1;
         end
         FMT_HCSL: begin
            clkPos_d = divClk;
            clkNeg_d = ~divClk;
            posOe_d  = (ctrl_q.driveModeB != HCSL_LOAD_TRISTATE); // R04
            negOe_d  = (ctrl_q.driveModeB != HCSL_LOAD_TRISTATE); // R04
         end
         FMT_LVCMOS: begin
            unique case (ocd_leg_t'(ctrl_q.driveModeA))
               LEG_OFF_TRISTATE: posOe_d = 1'b0; // R03
               LEG_OFF_LOW:      posOe_d = 1'b1; // R03
               LEG_ON_INVERTED: begin
                  posOe_d  = 1'b1;
                  clkPos_d = ~divClk; // R03
               end
               LEG_ON_TRUE: begin
                  posOe_d  = 1'b1;
                  clkPos_d = divClk; // R03
               end
            endcase
            unique case (ocd_leg_t'(ctrl_q.driveModeB))
               LEG_OFF_TRISTATE: negOe_d = 1'b0; // R04
               LEG_OFF_LOW:      negOe_d = 1'b1; // R04
               LEG_ON_INVERTED: begin
                  negOe_d  = 1'b1;
                  clkNeg_d = ~divClk; // R04
               end
               LEG_ON_TRUE: begin
                  negOe_d  = 1'b1;
                  clkNeg_d = divClk; // R04
               end
            endcase
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q      <= ocd_ctrl_t'(OUT6_CTRL_RESET);
         div_q       <= OUT6_DIV_RESET;
         activeSrc_q <= ocd_src_t'(OUT6_CTRL_RESET[7:6]);
         activeDiv_q <= OUT6_DIV_RESET;
         regRdData_q <= 8'h00;
         driverCfg_q <= ocd_ctrl_t'(OUT6_CTRL_RESET);
         clkPos_q    <= 1'b0;
         clkNeg_q    <= 1'b0;
         posOe_q     <= 1'b0;
         negOe_q     <= 1'b0;
      end else begin
         ctrl_q      <= ctrl_d;
         div_q       <= div_d;
         activeSrc_q <= activeSrc_d;
         activeDiv_q <= activeDiv_d;
         regRdData_q <= rdData_d;
         driverCfg_q <= ctrl_q;
         clkPos_q    <= clkPos_d;
         clkNeg_q    <= clkNeg_d;
         posOe_q     <= posOe_d;
         negOe_q     <= negOe_d;
      end
   end

endmodule : ocd_output6

// [core/ocd_pkg.sv]
// Constants and types shared by the output-six clock control block
package ocd_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   localparam logic [7:0] OUT6_CTRL_ADDR   = 8'h29;
   localparam logic [7:0] OUT6_DIV_ADDR    = 8'h2A;
   localparam logic [7:0] OUT6_STATUS_ADDR = 8'hF0;

   // Source 0, format 1, drive mode A 2, drive mode B 0
   localparam logic [7:0] OUT6_CTRL_RESET = 8'h18;
   localparam logic [7:0] OUT6_DIV_RESET  = 8'h05;

   localparam int STAT_SRC_LSB     = 0;
   localparam int STAT_PENDING_BIT = 2;

   typedef enum logic [1:0] {
      SRC_SYNTH_ONE     = 2'h0,
      SRC_SYNTH_TWO     = 2'h1,
      SRC_REF_PRIMARY   = 2'h2,
      SRC_REF_SECONDARY = 2'h3
   } ocd_src_t;

   typedef enum logic [1:0] {
      FMT_DISABLED = 2'h0,
      FMT_AC_DIFF  = 2'h1,
      FMT_HCSL     = 2'h2,
      FMT_LVCMOS   = 2'h3
   } ocd_fmt_t;

   // Drive-mode codes; differential meaning differs, CMOS leg meaning below
   typedef enum logic [1:0] {
      LEG_OFF_TRISTATE = 2'h0,
      LEG_OFF_LOW      = 2'h1,
      LEG_ON_INVERTED  = 2'h2,
      LEG_ON_TRUE      = 2'h3
   } ocd_leg_t;

   localparam logic [1:0] HCSL_LOAD_TRISTATE = 2'h0;

   // Field order matches the control register bit layout, msb first
   typedef struct packed {
      ocd_src_t source;
      ocd_fmt_t format;
      logic [1:0] driveModeA;
      logic [1:0] driveModeB;
   } ocd_ctrl_t;

endpackage : ocd_pkg

// [core/ocd_divider.sv]
// Edge-counting output divider with bypass and period-boundary strobe
`timescale 1ns/1ps
module ocd_divider
   import ocd_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       srcLevel,
   input  wire logic       bypass,
   input  wire logic [7:0] divRatio,
   output logic            divClk_q,
   output logic            boundary
);

   logic       srcPrev_q;
   logic [7:0] count_q;
   logic [7:0] count_d;
   logic       divClk_d;
   logic       srcRise;
   logic [8:0] highLen;

   assign srcRise  = srcLevel & ~srcPrev_q;
   // Boundary is a source edge that starts a fresh output period
   // A ratio taken while disabled may sit below the running count,
   // so the terminal test is >= to avoid a wrap through 256 counts
   assign boundary = srcRise & (bypass | (count_q >= divRatio)); // R07
   // High for ceil((N+1)/2) source periods
   assign highLen  = 9'((({1'b0, divRatio} + 9'h002) >> 1));

   always_comb begin
      count_d  = count_q;
      divClk_d = divClk_q;
      if (bypass || divRatio == 8'h00) begin
         count_d  = 8'h00;
         divClk_d = srcLevel; // R06
      end else if (srcRise) begin
         if (count_q >= divRatio) begin
            count_d = 8'h00; // R05
         end else begin
            count_d = 8'(count_q + 8'h01);
         end
         divClk_d = ({1'b0, count_d} < highLen);
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         srcPrev_q <= 1'b0;
         count_q   <= 8'h00;
         divClk_q  <= 1'b0;
      end else begin
         srcPrev_q <= srcLevel;
         count_q   <= count_d;
         divClk_q  <= divClk_d;
      end
   end

endmodule : ocd_divider

// [tb/ocd_output6_chk.sv]
// Port assertions for the output-six control block
`timescale 1ns/1ps
module ocd_output6_chk
   import ocd_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   input  wire logic [7:0] regRdData_q,
   input  wire ocd_ctrl_t  driverCfg_q,
   input  wire logic       clkPos_q,
   input  wire logic       clkNeg_q,
   input  wire logic       posOe_q,
   input  wire logic       negOe_q
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   property p_rdIdle;
      !regRead |=> regRdData_q == 8'h00;
   endproperty
   a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
   property p_ctlCopy;
      // Register takes the write at once, the copy one edge later
      regWrite && regAddr == OUT6_CTRL_ADDR
         |=> ##1 driverCfg_q == $past(regWrData, 2);
   endproperty
   a_ctlCopy: assert property (p_ctlCopy) else $error("cfg copy");
   property p_rdCfg;
      regRead && regAddr == OUT6_CTRL_ADDR |=> regRdData_q == driverCfg_q;
   endproperty
   a_rdCfg: assert property (p_rdCfg) else $error("ctrl readback");
   property p_off;
      driverCfg_q.format == FMT_DISABLED
         |-> !posOe_q && !negOe_q && !clkPos_q && !clkNeg_q;
   endproperty
   a_off: assert property (p_off) else $error("disabled pads");
   property p_diff;
      // Pads hold their reset value for one edge after release
      $past(reset_n) && driverCfg_q.format == FMT_AC_DIFF
         |-> posOe_q && negOe_q && clkNeg_q != clkPos_q;
   endproperty
   a_diff: assert property (p_diff) else $error("diff pads");
   property p_hcsl;
      driverCfg_q.format == FMT_HCSL
         && driverCfg_q.driveModeB != HCSL_LOAD_TRISTATE |-> posOe_q && negOe_q;
   endproperty
   a_hcsl: assert property (p_hcsl) else $error("hcsl enables");
   property p_posLow;
      driverCfg_q.format == FMT_LVCMOS && driverCfg_q.driveModeA == LEG_OFF_LOW
         |-> posOe_q && !clkPos_q;
   endproperty
   a_posLow: assert property (p_posLow) else $error("pos leg low");
   property p_negOff;
      driverCfg_q.format == FMT_LVCMOS
         && driverCfg_q.driveModeB == LEG_OFF_TRISTATE |-> !negOe_q;
   endproperty
   a_negOff: assert property (p_negOff) else $error("neg leg off");
   property p_legPol;
      driverCfg_q.format == FMT_LVCMOS && driverCfg_q.driveModeA == LEG_ON_TRUE
         && driverCfg_q.driveModeB == LEG_ON_INVERTED
         |-> posOe_q && negOe_q && clkPos_q != clkNeg_q;
   endproperty
   a_legPol: assert property (p_legPol) else $error("leg polarity");
endmodule : ocd_output6_chk
bind ocd_output6 ocd_output6_chk u_chk (.ref_clk, .reset_n, .regAddr,
   .regWrData, .regWrite, .regRead, .regRdData_q, .driverCfg_q, .clkPos_q,
   .clkNeg_q, .posOe_q, .negOe_q);

// [tb/ocd_output6_bench.sv]
// Register and clock-path tests for the output-six control block
`timescale 1ns/1ps
module ocd_output6_bench
   import ocd_pkg::*;
;
   logic       ref_clk = 0;
   logic       reset_n = 0;
   logic [7:0] regAddr = 0;
   logic [7:0] regWrData = 0;
   logic       regWrite = 0;
   logic       regRead = 0;
   logic       sOne = 0, sTwo = 0, rPri = 0, rSec = 0;
   logic [7:0] regRdData_q;
   ocd_ctrl_t  cfg;
   logic       clkPos_q, clkNeg_q, posOe_q, negOe_q;
   int         err_count = 0, n_tests = 0, tk = 0;
   int         pp[4] = '{4, 6, 8, 10};
   logic [1:0] ts[7] = '{0, 1, 1, 2, 3, 0, 0};
   logic [7:0] tn[7] = '{2, 1, 0, 3, 0, 255, 1};
   logic [7:0] fc[5] = '{8'h08, 8'h18, 8'h29, 8'h34, 8'h3E};
   logic [1:0] fe[5] = '{2'h0, 2'h3, 2'h3, 2'h2, 2'h3};
   always #5 ref_clk = ~ref_clk;
   // Source clocks of distinct periods so a wrong selection shows
   always @(posedge ref_clk) begin
      tk <= tk + 1;
      sOne <= (tk % 4) < 2;
      sTwo <= (tk % 6) < 3;
      rPri <= (tk % 8) < 4;
      rSec <= (tk % 10) < 5;
   end
   ocd_output6 dut (.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData_q(regRdData_q), .synthOneClk(sOne), .synthTwoClk(sTwo),
      .refPrimaryClk(rPri), .refSecondaryClk(rSec), .driverCfg_q(cfg),
      .clkPos_q(clkPos_q), .clkNeg_q(clkNeg_q), .posOe_q(posOe_q),
      .negOe_q(negOe_q));
   task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED %s exp %0h seen %0h", nm, e, s);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge ref_clk);
      regWrite <= 1'b0;
      @(posedge ref_clk);
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge ref_clk);
      regRead <= 1'b0;
      #1;
      chk("rdata", 16'(regRdData_q), 16'(e));
      @(posedge ref_clk);
   endtask : rd
   // Skips the first period, which may straddle a ratio change
   task per(input int e);
      int   n, k;
      logic prv;
      n = 0;
      k = 0;
      prv = 1'b1;
      while (k < 3 && n < 5000) begin
         @(negedge ref_clk);
         if (k == 2) n++;
         if (clkPos_q === 1'b1 && prv === 1'b0) k++;
         prv = clkPos_q;
      end
      chk("period", 16'(n), 16'(e));
      @(posedge ref_clk);
   endtask : per
   task end_of_test;
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test
   initial begin
      #400us;
      err_count++;
      end_of_test();
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      rd(OUT6_CTRL_ADDR, OUT6_CTRL_RESET);
      rd(OUT6_DIV_ADDR, OUT6_DIV_RESET);
      rd(8'h55, 8'h00);
      foreach (ts[i]) begin
         wr(OUT6_CTRL_ADDR, {ts[i], 2'h0, 4'h8});
         wr(OUT6_DIV_ADDR, tn[i]);
         wr(OUT6_CTRL_ADDR, {ts[i], 2'h1, 4'h8});
         per(ts[i] < 2 ? (tn[i] + 1) * pp[ts[i]] : pp[ts[i]]);
      end
      // Reprogram while running; new settings wait for a boundary
      wr(OUT6_DIV_ADDR, 8'h03);
      per(16);
      wr(OUT6_CTRL_ADDR, 8'h98);
      per(8);
      rd(OUT6_STATUS_ADDR, 8'h02);
      foreach (fc[i]) begin
         wr(OUT6_CTRL_ADDR, fc[i]);
         rd(OUT6_CTRL_ADDR, fc[i]);
         @(negedge ref_clk);
         chk("oe", 16'({posOe_q, negOe_q}), 16'(fe[i]));
         @(posedge ref_clk);
      end
      end_of_test();
   end
endmodule : ocd_output6_bench
